// >>> dccr_device.sv
// dccr_device: serial-port configuration register map of the dual-channel converter
`timescale 1ns/10ps
module dccr_device #(
    parameter logic [7:0] PART_ID = 8'h5A,   // arbitrary value
    parameter logic [2:0] SPEED_GRADE = 3'h5 // arbitrary value
) (
    input wire logic RST_IN,
    dccr_if.dev LINK,
    output logic [8*dccr_pkg::PROG_N-1:0] ACTIVE_A_OUT,
    output logic [8*dccr_pkg::PROG_N-1:0] ACTIVE_B_OUT,
    output logic LSB_FIRST_OUT,
    output logic [1:0] CHAN_SELECT_OUT
);
    // ==========================================================
    // reset crossing into the link clock
    // the link clock runs free, so a reset held four host cycles always meets a link edge
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic srst_reg;
    logic rst_any;

    always_ff @(posedge LINK.sclk) begin
        rst_meta_reg <= RST_IN;
        rst_sync_reg <= rst_meta_reg;
    end

    assign rst_any = rst_sync_reg | srst_reg;

    // ==========================================================
    // control registers
    logic lsb_reg;
    logic [1:0] chan_sel_reg;
    logic xfer_reg;

    // ==========================================================
    // frame decoder
    logic [3:0] bit_cnt_reg;
    logic in_data_reg;
    logic done_reg;
    logic is_read_reg;
    logic [1:0] len_reg;
    logic [1:0] byte_cnt_reg;
    logic [12:0] addr_reg;
    logic [14:0] shift_reg;
    logic [7:0] rd_byte_reg;
    logic [15:0] word_in;
    logic [15:0] instr;
    logic [7:0] byte_in;
    logic instr_end;
    logic byte_end;
    logic wr_en;
    logic last_byte;
    logic [12:0] addr_step;
    logic [12:0] rd_addr;
    logic [7:0] rd_data;

    assign word_in = {shift_reg, LINK.sdio};
    assign instr = lsb_reg ? dccr_pkg::dccr_rev16(word_in) : word_in;
    assign byte_in = lsb_reg ? dccr_pkg::dccr_rev8(word_in[7:0]) : word_in[7:0];
    assign instr_end = !LINK.serial_select_n && !in_data_reg && bit_cnt_reg == 4'hF;
    assign byte_end = !LINK.serial_select_n && in_data_reg && !done_reg && bit_cnt_reg == 4'h7;
    assign wr_en = byte_end && !is_read_reg;
    assign last_byte = len_reg != dccr_pkg::LEN_STREAM && byte_cnt_reg == len_reg;
    // address walks down in msb-first order and up in lsb-first order
    assign addr_step = lsb_reg ? 13'(addr_reg + 13'h0001) : 13'(addr_reg - 13'h0001);
    assign rd_addr = instr_end ? instr[12:0] : addr_step;

    always_ff @(posedge LINK.sclk) begin
        if (rst_any || LINK.serial_select_n) begin
            bit_cnt_reg <= 4'h0;
            in_data_reg <= 1'b0;
            done_reg <= 1'b0;
            is_read_reg <= 1'b0;
            byte_cnt_reg <= 2'h0;
        end else begin
            bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
            if (instr_end) begin
                bit_cnt_reg <= 4'h0;
                in_data_reg <= 1'b1;
                is_read_reg <= instr[dccr_pkg::INSTR_RW_BIT];
                len_reg <= instr[dccr_pkg::LEN_HI_BIT:dccr_pkg::LEN_LO_BIT];
            end else if (byte_end) begin
                bit_cnt_reg <= 4'h0;
                byte_cnt_reg <= 2'(byte_cnt_reg + 2'h1);
                done_reg <= last_byte;
            end
        end
    end

    always_ff @(posedge LINK.sclk) begin
        shift_reg <= word_in[14:0];
        if (instr_end) begin
            addr_reg <= instr[12:0];
        end else if (byte_end) begin
            addr_reg <= addr_step;
        end
        if (instr_end || byte_end) begin
            rd_byte_reg <= rd_data;
        end
    end

    // ==========================================================
    // register storage
    logic [7:0] sh_a [0:dccr_pkg::PROG_N-1];
    logic [7:0] sh_b [0:dccr_pkg::PROG_N-1];
    logic [7:0] act_a [0:dccr_pkg::PROG_N-1];
    logic [7:0] act_b [0:dccr_pkg::PROG_N-1];
    logic [7:0] feat [0:dccr_pkg::FEAT_N-1];
    logic in_prog;
    logic in_shadow;
    logic in_feat;
    logic [5:0] prog_idx;
    logic [4:0] feat_idx;
    logic wr_loc;

    assign in_prog = addr_reg >= dccr_pkg::PROG_FIRST && addr_reg <= dccr_pkg::PROG_LAST;
    assign in_shadow = addr_reg <= dccr_pkg::SHADOW_LAST;
    assign in_feat = addr_reg >= dccr_pkg::FEAT_FIRST && addr_reg <= dccr_pkg::FEAT_LAST;
    assign prog_idx = 6'(addr_reg - dccr_pkg::PROG_FIRST);
    assign feat_idx = 5'(addr_reg - dccr_pkg::FEAT_FIRST);
    assign wr_loc = dccr_pkg::PROG_LOCAL[prog_idx];

    always_ff @(posedge LINK.sclk) begin
        if (rst_any) begin
            for (int i = 0; i < dccr_pkg::PROG_N; i++) begin
                sh_a[i] <= (i == 0) ? dccr_pkg::RST_MODES : dccr_pkg::RST_PROG;
                sh_b[i] <= (i == 0) ? dccr_pkg::RST_MODES : dccr_pkg::RST_PROG;
                act_a[i] <= (i == 0) ? dccr_pkg::RST_MODES : dccr_pkg::RST_PROG;
                act_b[i] <= (i == 0) ? dccr_pkg::RST_MODES : dccr_pkg::RST_PROG;
            end
            for (int i = 0; i < dccr_pkg::FEAT_N; i++) begin
                feat[i] <= 8'h00;
            end
        end else begin
            if (xfer_reg) begin
                for (int i = 0; i < dccr_pkg::PROG_N; i++) begin
                    act_a[i] <= sh_a[i];
                    act_b[i] <= sh_b[i];
                end
            end
            // later assignments win, so a direct write in the transfer cycle is kept
            if (wr_en && in_prog) begin
                if (!wr_loc || chan_sel_reg[0]) begin
                    sh_a[prog_idx] <= byte_in;
                    if (!in_shadow) begin
                        act_a[prog_idx] <= byte_in;
                    end
                end
                if (!wr_loc || chan_sel_reg[1]) begin
                    sh_b[prog_idx] <= byte_in;
                    if (!in_shadow) begin
                        act_b[prog_idx] <= byte_in;
                    end
                end
            end
            if (wr_en && in_feat) begin
                feat[feat_idx] <= byte_in;
            end
        end
    end

    always_ff @(posedge LINK.sclk) begin
        if (rst_sync_reg || srst_reg) begin
            lsb_reg <= 1'b0;
            chan_sel_reg <= dccr_pkg::RST_CHAN_SEL[1:0];
            xfer_reg <= 1'b0;
            srst_reg <= 1'b0;
        end else begin
            // pulses only, so both bits clear on the following link edge
            xfer_reg <= wr_en && addr_reg == dccr_pkg::OFS_XFER && byte_in[dccr_pkg::XFER_BIT];
            srst_reg <= wr_en && addr_reg == dccr_pkg::OFS_PORT_CFG
                && (byte_in[dccr_pkg::PCFG_SRST_HI] || byte_in[dccr_pkg::PCFG_SRST_LO]);
            if (wr_en && addr_reg == dccr_pkg::OFS_PORT_CFG) begin
                lsb_reg <= byte_in[dccr_pkg::PCFG_LSB_HI] || byte_in[dccr_pkg::PCFG_LSB_LO];
            end
            if (wr_en && addr_reg == dccr_pkg::OFS_CHAN_SEL) begin
                chan_sel_reg <= byte_in[1:0];
            end
        end
    end

    // ==========================================================
    // read decode, addressed by the byte about to be shifted out
    logic rd_prog;
    logic rd_feat;
    logic [5:0] rd_pidx;
    logic [4:0] rd_fidx;

    assign rd_prog = rd_addr >= dccr_pkg::PROG_FIRST && rd_addr <= dccr_pkg::PROG_LAST;
    assign rd_feat = rd_addr >= dccr_pkg::FEAT_FIRST && rd_addr <= dccr_pkg::FEAT_LAST;
    assign rd_pidx = 6'(rd_addr - dccr_pkg::PROG_FIRST);
    assign rd_fidx = 5'(rd_addr - dccr_pkg::FEAT_FIRST);

    always_comb begin
        rd_data = 8'h00;
        if (rd_addr == dccr_pkg::OFS_PORT_CFG) begin
            rd_data = dccr_pkg::RST_PORT_CFG;
            rd_data[dccr_pkg::PCFG_LSB_HI] = lsb_reg;
            rd_data[dccr_pkg::PCFG_LSB_LO] = lsb_reg;
        end else if (rd_addr == dccr_pkg::OFS_PART_ID) begin
            rd_data = PART_ID;
        end else if (rd_addr == dccr_pkg::OFS_GRADE) begin
            rd_data = {1'b0, SPEED_GRADE, 4'h0};
        end else if (rd_addr == dccr_pkg::OFS_CHAN_SEL) begin
            rd_data = {6'h00, chan_sel_reg};
        end else if (rd_addr == dccr_pkg::OFS_XFER) begin
            rd_data = {7'h00, xfer_reg};
        end else if (rd_prog) begin
            // a global entry holds equal copies, so channel A serves it
            if (dccr_pkg::PROG_LOCAL[rd_pidx] && !chan_sel_reg[0]) begin
                rd_data = sh_b[rd_pidx];
            end else begin
                rd_data = sh_a[rd_pidx];
            end
        end else if (rd_feat) begin
            rd_data = feat[rd_fidx];
        end
    end

    // ==========================================================
    // data out, changed on the falling link edge so the host samples on the rising one
    logic dout_reg;
    logic doe_reg;

    always_ff @(negedge LINK.sclk) begin
        doe_reg <= !rst_any && in_data_reg && is_read_reg && !done_reg;
        dout_reg <= lsb_reg ? rd_byte_reg[bit_cnt_reg[2:0]] : rd_byte_reg[3'(3'h7 - bit_cnt_reg[2:0])];
    end

    assign LINK.dev_sdio = dout_reg;
    assign LINK.dev_sdio_oe = doe_reg;
    assign LSB_FIRST_OUT = lsb_reg;
    assign CHAN_SELECT_OUT = chan_sel_reg;

    for (genvar g = 0; g < dccr_pkg::PROG_N; g++) begin : g_active
        assign ACTIVE_A_OUT[g*8 +: 8] = act_a[g];
        assign ACTIVE_B_OUT[g*8 +: 8] = act_b[g];
    end
endmodule : dccr_device

// >>> dccr_pkg.sv
// dccr_pkg: shared constants of the dual-channel configuration register map and its serial link
package dccr_pkg;
    // ==========================================================
    // serial frame
    localparam int INSTR_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam int ADDR_W = 13;
    localparam int INSTR_RW_BIT = 15;
    localparam int LEN_HI_BIT = 14;
    localparam int LEN_LO_BIT = 13;
    localparam logic [1:0] LEN_STREAM = 2'h3;
    // ==========================================================
    // device register map
    localparam logic [12:0] OFS_PORT_CFG = 13'h0000;
    localparam logic [12:0] OFS_PART_ID = 13'h0001;
    localparam logic [12:0] OFS_GRADE = 13'h0002;
    localparam logic [12:0] OFS_CHAN_SEL = 13'h0005;
    localparam logic [12:0] OFS_XFER = 13'h00FF;
    localparam logic [12:0] PROG_FIRST = 13'h0008;
    localparam logic [12:0] SHADOW_LAST = 13'h0018;
    localparam logic [12:0] PROG_LAST = 13'h002E;
    localparam logic [12:0] FEAT_FIRST = 13'h0100;
    localparam logic [12:0] FEAT_LAST = 13'h011D;
    localparam int PROG_N = 39;
    localparam int FEAT_N = 30;
    // program entries kept per channel: modes (index 0) and test mode (index 5)
    localparam logic [38:0] PROG_LOCAL = 39'h00_0000_0021;
    // ==========================================================
    // field positions and reset values
    localparam int PCFG_LSB_HI = 6;
    localparam int PCFG_SRST_HI = 5;
    localparam int PCFG_SRST_LO = 2;
    localparam int PCFG_LSB_LO = 1;
    localparam logic [7:0] RST_PORT_CFG = 8'h18;
    localparam logic [7:0] RST_CHAN_SEL = 8'h03;
    localparam logic [7:0] RST_MODES = 8'h80;
    localparam logic [7:0] RST_PROG = 8'h00;
    localparam int XFER_BIT = 0;
    // ==========================================================
    // host register port
    localparam logic [4:0] HOST_OFS_INSTR = 5'h00;
    localparam logic [4:0] HOST_OFS_TXDATA = 5'h04;
    localparam logic [4:0] HOST_OFS_CTRL = 5'h08;
    localparam logic [4:0] HOST_OFS_RXDATA = 5'h0C;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_LSB_BIT = 1;
    localparam int HOST_DIV_HALF = 4;
    localparam int FRAME_MAX = 48;

    function automatic logic [7:0] dccr_rev8(input logic [7:0] x);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = x[7 - i];
        end
        return r;
    endfunction : dccr_rev8

    function automatic logic [15:0] dccr_rev16(input logic [15:0] x);
        return {dccr_rev8(x[7:0]), dccr_rev8(x[15:8])};
    endfunction : dccr_rev16
endpackage : dccr_pkg

// >>> dccr_if.sv
// dccr_if: three-wire serial link between host controller and configuration device
`timescale 1ns/10ps
interface dccr_if;
    logic sclk;
    logic serial_select_n;
    logic host_sdio;
    logic host_sdio_oe;
    logic dev_sdio;
    logic dev_sdio_oe;
    logic sdio;

    // ==========================================================
    // shared data wire, pulled high when nobody drives
    assign sdio = host_sdio_oe ? host_sdio : (dev_sdio_oe ? dev_sdio : 1'b1);

    modport host (
        output sclk,
        output serial_select_n,
        output host_sdio,
        output host_sdio_oe,
        input sdio
    );

    modport dev (
        input sclk,
        input serial_select_n,
        input sdio,
        output dev_sdio,
        output dev_sdio_oe
    );
endinterface : dccr_if

// >>> dccr_host.sv
// dccr_host: serial host controller that frames register accesses to the configuration device
`timescale 1ns/10ps
module dccr_host #(
    parameter int DIV_HALF = dccr_pkg::HOST_DIV_HALF
) (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic [4:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [31:0] RDATA_OUT,
    dccr_if.host LINK
);
    typedef enum logic [1:0] {
        DCCR_IDLE = 2'b01,
        DCCR_RUN = 2'b10
    } dccr_hstate_t;

    // ==========================================================
    // register port
    logic [15:0] instr_reg;
    logic [31:0] tx_reg;
    logic [31:0] rx_reg;
    logic lsb_reg;
    logic pend_reg;
    logic [31:0] rdata_reg;
    dccr_hstate_t state_reg;
    logic busy;

    assign busy = pend_reg || state_reg == DCCR_RUN;

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            instr_reg <= 16'h0000;
            tx_reg <= 32'h0000_0000;
            lsb_reg <= 1'b0;
        end else if (WR_IN && !busy) begin
            // host writes open bits as zero: software supplies clean bytes
            if (ADDR_IN == dccr_pkg::HOST_OFS_INSTR) begin
                instr_reg <= WDATA_IN[15:0];
            end
            if (ADDR_IN == dccr_pkg::HOST_OFS_TXDATA) begin
                tx_reg <= WDATA_IN;
            end
            if (ADDR_IN == dccr_pkg::HOST_OFS_CTRL) begin
                lsb_reg <= WDATA_IN[dccr_pkg::CTRL_LSB_BIT];
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            rdata_reg <= 32'h0000_0000;
        end else if (RD_IN) begin
            case (ADDR_IN)
                dccr_pkg::HOST_OFS_INSTR: rdata_reg <= {16'h0000, instr_reg};
                dccr_pkg::HOST_OFS_TXDATA: rdata_reg <= tx_reg;
                dccr_pkg::HOST_OFS_CTRL: rdata_reg <= {30'h0000_0000, lsb_reg, busy};
                dccr_pkg::HOST_OFS_RXDATA: rdata_reg <= rx_reg;
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign RDATA_OUT = rdata_reg;

    // ==========================================================
    // free-running link clock divider
    logic [7:0] div_cnt_reg;
    logic sclk_reg;
    logic wrap;
    logic fall_ev;
    logic rise_ev;

    assign wrap = div_cnt_reg == 8'(DIV_HALF - 1);
    assign fall_ev = wrap && sclk_reg;
    assign rise_ev = wrap && !sclk_reg;

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            // keep toggling in reset: the device only sees its reset on link edges
            if (div_cnt_reg == 8'h01) begin
                div_cnt_reg <= 8'h00;
            end else begin
                div_cnt_reg <= 8'h01;
            end
            sclk_reg <= div_cnt_reg[0];
        end else begin
            div_cnt_reg <= wrap ? 8'h00 : 8'(div_cnt_reg + 8'h01);
            if (wrap) begin
                sclk_reg <= !sclk_reg;
            end
        end
    end

    // ==========================================================
    // returning data passes two flops before use
    logic sdio_meta_reg;
    logic sdio_sync_reg;

    always_ff @(posedge CLK_IN) begin
        sdio_meta_reg <= LINK.sdio;
        sdio_sync_reg <= sdio_meta_reg;
    end

    // ==========================================================
    // frame sequencer
    logic [47:0] frame_reg;
    logic [5:0] total_reg;
    logic [5:0] bit_idx_reg;
    logic is_read_reg;
    logic fr_lsb_reg;
    logic csn_reg;
    logic dout_reg;
    logic doe_reg;
    logic [47:0] frame_next;
    logic [5:0] j;
    logic lsb_now;

    // the start write may carry a new bit order, which must shape this very frame
    assign lsb_now = (ADDR_IN == dccr_pkg::HOST_OFS_CTRL) ? WDATA_IN[dccr_pkg::CTRL_LSB_BIT] : lsb_reg;

    always_comb begin
        frame_next = {dccr_pkg::dccr_rev16(instr_reg), dccr_pkg::dccr_rev8(tx_reg[7:0]),
            dccr_pkg::dccr_rev8(tx_reg[15:8]), dccr_pkg::dccr_rev8(tx_reg[23:16]),
            dccr_pkg::dccr_rev8(tx_reg[31:24])};
        if (!lsb_now) begin
            frame_next = {instr_reg, tx_reg[7:0], tx_reg[15:8], tx_reg[23:16], tx_reg[31:24]};
        end
    end

    assign j = 6'(bit_idx_reg - 6'h10);

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            state_reg <= DCCR_IDLE;
            pend_reg <= 1'b0;
            csn_reg <= 1'b1;
            dout_reg <= 1'b0;
            doe_reg <= 1'b0;
            bit_idx_reg <= 6'h00;
            rx_reg <= 32'h0000_0000;
        end else begin
            if (WR_IN && !busy && ADDR_IN == dccr_pkg::HOST_OFS_CTRL && WDATA_IN[dccr_pkg::CTRL_START_BIT]) begin
                pend_reg <= 1'b1;
                frame_reg <= frame_next;
                total_reg <= 6'(dccr_pkg::INSTR_BITS + dccr_pkg::BYTE_BITS * (int'(instr_reg[14:13]) + 1));
                is_read_reg <= instr_reg[dccr_pkg::INSTR_RW_BIT];
                fr_lsb_reg <= lsb_now;
            end
            case (state_reg)
                DCCR_IDLE: begin
                    if (pend_reg && fall_ev) begin
                        pend_reg <= 1'b0;
                        state_reg <= DCCR_RUN;
                        csn_reg <= 1'b0;
                        dout_reg <= frame_reg[47];
                        doe_reg <= 1'b1;
                        bit_idx_reg <= 6'h00;
                    end
                end
                DCCR_RUN: begin
                    if (rise_ev) begin
                        bit_idx_reg <= 6'(bit_idx_reg + 6'h01);
                        if (is_read_reg && bit_idx_reg >= 6'h10) begin
                            rx_reg[{j[4:3], fr_lsb_reg ? j[2:0] : 3'(3'h7 - j[2:0])}] <= sdio_sync_reg;
                        end
                    end else if (fall_ev) begin
                        if (bit_idx_reg == total_reg) begin
                            state_reg <= DCCR_IDLE;
                            csn_reg <= 1'b1;
                            doe_reg <= 1'b0;
                        end else begin
                            dout_reg <= frame_reg[6'(6'd47 - bit_idx_reg)];
                            doe_reg <= !is_read_reg || bit_idx_reg < 6'h10;
                        end
                    end
                end
                default: state_reg <= DCCR_IDLE;
            endcase
        end
    end

    assign LINK.sclk = sclk_reg;
    assign LINK.serial_select_n = csn_reg;
    assign LINK.host_sdio = dout_reg;
    assign LINK.host_sdio_oe = doe_reg;
endmodule : dccr_host

// >>> dccr_chk.sv
// dccr_chk: link assertions on the serial frame between host and device
`timescale 1ns/10ps
module dccr_chk (
    input wire logic RST_IN,
    input wire logic sclk,
    input wire logic serial_select_n,
    input wire logic host_sdio_oe,
    input wire logic dev_sdio_oe
);
    // ==========================================================
    // helper: rises seen in the current frame
    // live_reg masks the first edges, when sampled history still predates reset
    logic [5:0] rise_reg = 6'h00;
    logic [1:0] live_reg = 2'h0;
    always_ff @(posedge sclk) begin
        live_reg <= RST_IN ? 2'h0 : {live_reg[0], 1'b1};
    end
    always_ff @(posedge sclk) begin
        rise_reg <= (RST_IN || serial_select_n) ? 6'h00 : rise_reg + 6'h01;
    end
    default clocking @(posedge sclk); endclocking
    default disable iff (RST_IN || !live_reg[1]);
    // ==========================================================
    // assertions
    a_no_contention: assert property (!(host_sdio_oe && dev_sdio_oe))
        else $error("both ends drive the data wire");
    a_idle_quiet: assert property ($past(serial_select_n) && serial_select_n |-> !dev_sdio_oe)
        else $error("device drives outside a frame");
    a_read_turn: assert property ($rose(dev_sdio_oe) |-> rise_reg == 6'h10 && !serial_select_n)
        else $error("device drive does not start after sixteen bits");
    a_host_turn: assert property ($fell(host_sdio_oe) && !serial_select_n |-> rise_reg == 6'h10)
        else $error("host releases wire at wrong bit");
    a_frame_start: assert property ($fell(serial_select_n) |-> host_sdio_oe && rise_reg == 6'h00)
        else $error("frame opens without host drive");
    a_instr_driven: assert property (!serial_select_n && rise_reg < 6'h10 |-> host_sdio_oe)
        else $error("instruction bits not driven by host");
    a_frame_len: assert property ($rose(serial_select_n) |-> rise_reg inside {6'h18, 6'h20, 6'h28, 6'h30})
        else $error("frame is not instruction plus whole bytes");
    a_dev_byte: assert property ($rose(dev_sdio_oe) |-> dev_sdio_oe [*8])
        else $error("device returns less than a byte");
    c_read: cover property ($rose(dev_sdio_oe));
    c_write1: cover property ($rose(serial_select_n) && rise_reg == 6'h18);
    c_multi: cover property ($rose(serial_select_n) && rise_reg == 6'h20);
endmodule : dccr_chk

// >>> tb_dual_channel_config_register_map.sv
// tb_dual_channel_config_register_map: host controller and device joined over the serial link
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module tb_dual_channel_config_register_map;
    localparam logic [7:0] PID = 8'hA7; // arbitrary value
    localparam logic [2:0] GRD = 3'h2; // arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] addr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [311:0] act_a;
    logic [311:0] act_b;
    logic lsb_out;
    logic [1:0] chan;
    logic lsb = 1'b0;
    logic [31:0] r;
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;
    dccr_if lnk ();
    dccr_host dccr_host_i (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .LINK(lnk.host));
    dccr_device #(.PART_ID(PID), .SPEED_GRADE(GRD)) dccr_device_i (.RST_IN(rst), .LINK(lnk.dev),
        .ACTIVE_A_OUT(act_a), .ACTIVE_B_OUT(act_b), .LSB_FIRST_OUT(lsb_out), .CHAN_SELECT_OUT(chan));
    dccr_chk dccr_chk_i (.RST_IN(rst), .sclk(lnk.sclk), .serial_select_n(lnk.serial_select_n),
        .host_sdio_oe(lnk.host_sdio_oe), .dev_sdio_oe(lnk.dev_sdio_oe));
    initial begin
        forever #20 clk = ~clk;
    end
    // ==========================================================
    // closing and hang guard
    task tally_and_finish();
        if (errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            $display("ERROR %0t timeout", $time);
            tally_and_finish();
        end
    end
    // ==========================================================
    // host port access: one strobe cycle, then a gap so strobes never re-assert in one step
    task bus(input logic [4:0] a, input logic [31:0] d, input logic w);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 r = rdata;
        @(posedge clk);
    endtask : bus
    task xf(input logic [15:0] ins, input logic [31:0] tx);
        bus(dccr_pkg::HOST_OFS_INSTR, {16'h0000, ins}, 1'b1);
        bus(dccr_pkg::HOST_OFS_TXDATA, tx, 1'b1);
        bus(dccr_pkg::HOST_OFS_CTRL, {30'h0, lsb, 1'b1}, 1'b1);
        for (int i = 0; i < 400; i++) begin
            bus(dccr_pkg::HOST_OFS_CTRL, 32'h0, 1'b0);
            if (r[0] === 1'b0) break;
        end
        bus(dccr_pkg::HOST_OFS_RXDATA, 32'h0, 1'b0);
    endtask : xf
    task w1(input logic [12:0] a, input logic [7:0] d); // callers write mapped addresses only
        xf({3'h0, a}, {24'h0, d});
    endtask : w1
    task r1(input logic [12:0] a);
        xf({3'h4, a}, 32'h0);
    endtask : r1
    // ==========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (32) @(posedge clk);
        r1(dccr_pkg::OFS_PORT_CFG);
        `CHK(r[7:0], dccr_pkg::RST_PORT_CFG)
        r1(dccr_pkg::OFS_CHAN_SEL);
        `CHK(r[7:0], dccr_pkg::RST_CHAN_SEL)
        w1(dccr_pkg::OFS_PART_ID, 8'h00);
        r1(dccr_pkg::OFS_PART_ID);
        `CHK(r[7:0], PID)
        r1(dccr_pkg::OFS_GRADE);
        `CHK(r[7:0], {1'b0, GRD, 4'h0})
        r1(13'h0013);
        `CHK(r[7:0], 8'h00)
        w1(13'h0009, 8'h01);
        w1(dccr_pkg::SHADOW_LAST, 8'h33);
        w1(13'h0019, 8'h44);
        repeat (32) @(posedge clk);
        `CHK({act_a[15:8], act_a[135:128]}, 16'h0000)
        `CHK(act_a[143:136], 8'h44)
        r1(13'h0009);
        `CHK(r[7:0], 8'h01)
        w1(dccr_pkg::OFS_CHAN_SEL, 8'h01); // open bits written as zero
        w1(13'h000D, 8'h05);
        w1(dccr_pkg::OFS_CHAN_SEL, 8'h02);
        w1(13'h000D, 8'h0A);
        w1(dccr_pkg::OFS_CHAN_SEL, 8'h03);
        w1(13'h0008, 8'h81);
        w1(dccr_pkg::OFS_XFER, 8'h01);
        repeat (32) @(posedge clk);
        `CHK({act_b[15:8], act_a[135:128]}, 16'h0133)
        `CHK({act_a[47:40], act_b[47:40]}, 16'h050A)
        `CHK({act_a[7:0], act_b[7:0], chan}, 18'h20607)
        r1(dccr_pkg::OFS_XFER);
        `CHK(r[7:0], 8'h00)
        r1(13'h000D);
        `CHK(r[7:0], 8'h05)
        w1(dccr_pkg::OFS_CHAN_SEL, 8'h02);
        r1(13'h000D);
        `CHK(r[7:0], 8'h0A)
        xf({3'h2, 13'h0101}, 32'h0000C3B4);
        xf({3'h6, 13'h0101}, 32'h0);
        `CHK(r[15:0], 16'hC3B4)
        w1(dccr_pkg::OFS_PORT_CFG, 8'h42);
        lsb = 1'b1;
        `CHK(lsb_out, 1'b1)
        r1(dccr_pkg::OFS_PORT_CFG);
        `CHK(r[7:0], 8'h5A)
        // mirrored soft reset bits decode the same in either shift order
        w1(dccr_pkg::OFS_PORT_CFG, 8'h24);
        lsb = 1'b0;
        repeat (32) @(posedge clk);
        `CHK({lsb_out, chan, act_a[7:0]}, {3'h3, dccr_pkg::RST_MODES})
        r1(13'h0009);
        `CHK(r[7:0], dccr_pkg::RST_PROG)
        tally_and_finish();
    end
endmodule : tb_dual_channel_config_register_map
